// *** rtl/dct_pkg.sv ***
// dct_pkg: register map, field layout and codes of the dual 8/16-bit composite timer
// assumes an apb slave with 32-bit data and a 20 mhz pclk
// Function
// - upper output holds when stopped
// - upper output reads zero when undefined
// - lower output reads zero in capture
// - function change restores last or zero
// - source select picks external or internal lower input
// - join bit cascades timers into sixteen bits
// - start in variable pwm clears join
// - join write ignored while running
// - upper input filter four encodings
// - lower input filter four encodings
// - filter writes locked while lower runs; filters off outside measuring and capture
// - interval loads latch, clears count on match except free-running
// - fixed pwm high, low on match
// - variable pwm low width and period
// - pulse result stored, flag set, read clears
// - high pulse stored despite flag
// - capture edge copies counter into data
// - software write overwrites stored result
// - upper read buffers lower value
// - lower write moves write buffer up
// - run enable clears count, starts zero
package dct_pkg;
  localparam int ADDR_W = 16;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_UDATA = 12'hf94;
  localparam logic [11:0] IDX_LDATA = 12'hf95;
  localparam logic [11:0] IDX_MODE = 12'hf96;
  localparam logic [11:0] IDX_LCTRL = 12'hf97;
  localparam logic [11:0] IDX_UCTRL = 12'hf98;
  // mode control fields
  localparam int MC_SRC = 5;
  localparam int MC_JOIN = 4;
  localparam int MC_UFLT = 2;
  localparam int MC_LFLT = 0;
  // per-timer control fields: run 7, flag 6, initial output 4, function 3:0
  localparam int CR_RUN = 7;
  localparam int CR_SO = 4;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] FN_RST = 4'h0;
  // function select codes
  localparam logic [3:0] FN_ONE = 4'h0;
  localparam logic [3:0] FN_CONT = 4'h1;
  localparam logic [3:0] FN_FREE = 4'h2;
  localparam logic [3:0] FN_PWMF = 4'h3;
  localparam logic [3:0] FN_PWMV = 4'h4;
  localparam logic [3:0] FN_PWH = 4'h5;
  localparam logic [3:0] FN_PWL = 4'h6;
  localparam logic [3:0] FN_PWCR = 4'h7;
  localparam logic [3:0] FN_PWCF = 4'h8;
  localparam logic [3:0] FN_PWHC = 4'h9;
  localparam logic [3:0] FN_CAPR = 4'ha;
  localparam logic [3:0] FN_CAPF = 4'hb;
  localparam logic [15:0] TOP8 = 16'h00ff;
  localparam logic [15:0] TOP16 = 16'hffff;
  localparam int CLK_HZ = 20000000;
  typedef enum logic {PW_IDLE = 1'b0, PW_MEAS = 1'b1} dct_pw_t;
endpackage

// *** rtl/dct_timer.sv ***
// dct_timer: two 8-bit timers joinable into one 16-bit timer, apb register access
// assumes inputs synchronous to pclk and a zero-wait apb master
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module dct_timer #(
  parameter int CNT_DIV = 1
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [dct_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic lower_external_input,
  input logic upper_external_input,
  input logic internal_capture_source,
  output logic lower_timer_out,
  output logic upper_timer_out
);
  import dct_pkg::*;

  if (CNT_DIV < 1 || CNT_DIV > 256) begin : g_chk
    $error("CNT_DIV must be 1 to 256");
  end

  // ***************************************************
  // bus decode
  // ***************************************************
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [1:0][7:0] data_reg;
  logic [1:0][3:0] fn_reg;
  logic [1:0][1:0] flt_reg;
  logic [1:0] so_reg;
  logic [1:0] run_reg;
  logic [1:0] run_next;
  logic [1:0] bf_reg;
  logic join_reg;
  logic src_reg;
  logic [7:0] rbuf_reg;
  logic [7:0] wbuf_reg;
  logic [7:0] div_reg;
  logic tick_reg;
  logic [1:0][15:0] cntw;
  logic [1:0][15:0] stv;
  logic [1:0] ost;
  logic [1:0] hitw;
  logic [1:0] strtw;
  logic [1:0] st;
  logic [1:0] pst;
  logic [1:0] stopw;

  wire setup = psel & ~penable;
  wire done = psel & penable & pready_reg;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire [11:0] idx = paddr[13:2];
  wire al = (paddr[15:14] == 2'b00) && (paddr[1:0] == 2'b00);
  wire s_ud = al && idx == IDX_UDATA;
  wire s_ld = al && idx == IDX_LDATA;
  wire s_mc = al && idx == IDX_MODE;
  wire s_lc = al && idx == IDX_LCTRL;
  wire s_uc = al && idx == IDX_UCTRL;
  wire mapped = s_ud | s_ld | s_mc | s_lc | s_uc;
  wire [7:0] wb = pwdata[7:0];
  wire [1:0] wr_dat = {wr & s_ud, wr & s_ld};
  wire [1:0] wr_ctl = {wr & s_uc, wr & s_lc};
  wire wr_mc = wr & s_mc;
  wire rd_ld = rd & s_ld;
  wire rd_ud = rd & s_ud;

  // shared run: joined or variable pwm both timers start and stop together
  wire var0 = fn_reg[0] == FN_PWMV;
  wire shared = join_reg | var0;
  wire buf16 = join_reg & var0;
  wire rv = wb[CR_RUN];
  wire start_req = (wr_ctl[0] & rv & ~run_reg[0]) | (wr_ctl[1] & rv & ~run_reg[1]);
  wire [1:0] stops = shared ? {2{|stopw}} : stopw;
  wire [1:0] intf = {fn_reg[1] <= FN_FREE, fn_reg[0] <= FN_FREE};
  wire [1:0] zblk = {2{~join_reg & (wb == 8'h00)}} & intf;
  wire [1:0] showc = {fn_reg[1] <= FN_PWMV, fn_reg[0] <= FN_PWMV};
  wire [1:0] capf = {fn_reg[1] >= FN_CAPR, fn_reg[0] >= FN_CAPR};

  // ***************************************************
  // read path
  // ***************************************************
  // counting functions read the live count, measuring ones the stored result
  wire [7:0] lraw = showc[0] ? cntw[0][7:0] : data_reg[0];
  wire [7:0] lval = buf16 ? rbuf_reg : lraw;
  wire [7:0] uval = join_reg ? (showc[0] ? cntw[0][15:8] : data_reg[1])
                             : (showc[1] ? cntw[1][7:0] : data_reg[1]);
  wire uo_ok = ~join_reg & ~var0 & (fn_reg[1] != FN_PWMV) & ~capf[1];
  wire [7:0] mval = {ost[1] & uo_ok, ost[0] & ~capf[0], src_reg, join_reg,
                     flt_reg[1], flt_reg[0]};
  wire [7:0] lcv = {run_reg[0], bf_reg[0], 1'b0, so_reg[0], fn_reg[0]};
  wire [7:0] ucv = {run_reg[1], bf_reg[1], 1'b0, so_reg[1], fn_reg[1]};
  wire [7:0] rmux = s_ld ? lval : s_ud ? uval : s_mc ? mval : s_lc ? lcv : s_uc ? ucv : 8'h00;

  // registered answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_reg <= {24'h0, rmux};
      end
    end
  end

  // count clock divider; a slower count rate is a one-cycle enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= div_reg == 8'(CNT_DIV - 1);
      div_reg <= (div_reg == 8'(CNT_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // ***************************************************
  // control and mode registers
  // ***************************************************
  always_comb begin
    run_next = run_reg & ~stops;
    if (wr_ctl[0]) begin
      run_next = shared ? {2{rv}} : {run_next[1], rv};
    end
    if (wr_ctl[1]) begin
      run_next = shared ? {2{rv}} : {rv, run_next[0]};
    end
  end

  // function and initial output only change while the timer is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn_reg <= {FN_RST, FN_RST};
      so_reg <= 2'b00;
      run_reg <= 2'b00;
      join_reg <= 1'b0;
      src_reg <= 1'b0;
      flt_reg <= '0;
    end else begin
      run_reg <= run_next;
      for (int j = 0; j < 2; j++) begin
        if (wr_ctl[j] && !run_reg[j]) begin
          fn_reg[j] <= wb[3:0];
        end
        if (wr_ctl[j] && run_reg == 2'b00) begin
          so_reg[j] <= wb[CR_SO];
        end
      end
      if (wr_mc) begin
        src_reg <= wb[MC_SRC];
      end
      if (start_req && join_reg && var0) begin
        join_reg <= 1'b0;
      end else if (wr_mc && run_reg == 2'b00) begin
        join_reg <= wb[MC_JOIN];
      end
      if (wr_mc && !run_reg[0]) begin
        flt_reg <= {wb[MC_UFLT +: 2], wb[MC_LFLT +: 2]};
      end
    end
  end

  // result-held flags: a new result wins over a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bf_reg <= 2'b00;
    end else begin
      bf_reg[0] <= pst[0] | (bf_reg[0] & ~(join_reg ? rd_ud : rd_ld));
      bf_reg[1] <= ~join_reg & (pst[1] | (bf_reg[1] & ~rd_ud));
    end
  end

  // data registers; a software write lands after a same-cycle result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= {DATA_RST, DATA_RST};
      rbuf_reg <= DATA_RST;
      wbuf_reg <= DATA_RST;
    end else begin
      if (st[0]) begin
        data_reg[0] <= stv[0][7:0];
        if (join_reg) begin
          data_reg[1] <= stv[0][15:8];
        end
      end
      if (st[1] && !join_reg) begin
        data_reg[1] <= stv[1][7:0];
      end
      if (rd_ud && buf16) begin
        rbuf_reg <= lraw;
      end
      if (wr_dat[1]) begin
        if (buf16) begin
          wbuf_reg <= wb;
        end else if (!zblk[1]) begin
          data_reg[1] <= wb;
        end
      end
      if (wr_dat[0]) begin
        if (buf16) begin
          data_reg[0] <= wb;
          data_reg[1] <= wbuf_reg;
        end else if (!zblk[0]) begin
          data_reg[0] <= wb;
        end
      end
    end
  end

  // ***************************************************
  // per-timer counters, input filters and measurement
  // ***************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [15:0] cnt_reg;
    logic [15:0] lat_reg;
    logic ost_reg;
    logic sav_reg;
    logic [3:0] lfn_reg;
    logic runq_reg;
    logic [1:0] smp_reg;
    logic fin_reg;
    logic fq_reg;
    dct_pw_t pw_reg;

    wire [3:0] fn = var0 ? FN_PWMV : fn_reg[i]; // variable pwm makes the upper counter the period counter
    wire jn = join_reg & (i == 0);
    wire act = run_reg[i] & ~(join_reg & (i == 1));
    wire [15:0] top = jn ? TOP16 : TOP8;
    wire [15:0] cmpd = jn ? {data_reg[1], data_reg[0]} : {8'h00, data_reg[i]};
    wire strt = act & ~runq_reg;
    wire hit = tick_reg & act & (cnt_reg == lat_reg);
    wire ovf = tick_reg & act & (cnt_reg == top);
    wire [15:0] nxt = (cnt_reg == top) ? 16'h0000 : cnt_reg + 16'h0001;
    wire isint = fn <= FN_FREE;
    wire isfix = fn == FN_PWMF;
    wire isvar = fn == FN_PWMV;
    wire ispwc = fn >= FN_PWH && fn <= FN_PWHC;
    wire iscap = fn >= FN_CAPR;
    wire hc = fn == FN_PWHC;
    wire cyc = fn == FN_PWCR || fn == FN_PWCF;
    // filters act only while measuring or capturing
    wire [1:0] fen = (ispwc | iscap) ? flt_reg[i] : 2'b00;
    wire raw = (i == 0) ? (src_reg ? internal_capture_source : lower_external_input)
                        : upper_external_input;
    wire rise_ok = fen[0] ? (smp_reg[1] & smp_reg[0]) : smp_reg[0];
    wire fall_ok = fen[1] ? ~(smp_reg[1] | smp_reg[0]) : ~smp_reg[0];
    wire re = fin_reg & ~fq_reg;
    wire fe = ~fin_reg & fq_reg;
    wire sedg = (fn == FN_PWL || fn == FN_PWCF) ? fe : re;
    wire eedg = (fn == FN_PWH || fn == FN_PWCF || hc) ? fe : re;
    wire meas = ispwc & act & (pw_reg == PW_MEAS);
    wire pend = meas & eedg;
    wire hcyc = meas & hc & re;
    wire cedg = (fn == FN_CAPR) ? re : (fn == FN_CAPF) ? fe : (re | fe);
    wire fchg = wr_ctl[i] & ~run_reg[i] & (wb[3:0] != fn_reg[i]);
    wire pm1 = (i == 0) & isvar & hitw[1];

    // a held flag blocks a new result, except the high pulse of the combined mode
    assign pst[i] = (pend & (~bf_reg[i] | hc)) | (hcyc & ~bf_reg[i]);
    assign st[i] = pst[i] | (iscap & act & cedg);
    assign stv[i] = cnt_reg;
    assign cntw[i] = cnt_reg;
    assign ost[i] = ost_reg;
    assign hitw[i] = hit;
    assign strtw[i] = strt;
    assign stopw[i] = hit & (fn == FN_ONE);

    // input sampling and pulse noise removal
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        smp_reg <= 2'b00;
        fin_reg <= 1'b0;
        fq_reg <= 1'b0;
      end else begin
        smp_reg <= {smp_reg[0], raw};
        fin_reg <= rise_ok ? 1'b1 : (fall_ok ? 1'b0 : fin_reg);
        fq_reg <= fin_reg;
      end
    end

    // counter, comparator latch and measurement state
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg <= 16'h0000;
        lat_reg <= 16'h0000;
        runq_reg <= 1'b0;
        pw_reg <= PW_IDLE;
      end else begin
        runq_reg <= act;
        if (!act) begin
          cnt_reg <= 16'h0000;
          pw_reg <= PW_IDLE;
        end else if (strt) begin
          cnt_reg <= 16'h0000;
          lat_reg <= cmpd;
          pw_reg <= PW_IDLE;
        end else if (ispwc) begin
          if (pw_reg == PW_IDLE) begin
            if (sedg) begin
              cnt_reg <= 16'h0000;
              pw_reg <= PW_MEAS;
            end
          end else if (hcyc || (pend && cyc)) begin
            cnt_reg <= 16'h0000;
          end else if (pend && !hc) begin
            pw_reg <= PW_IDLE;
          end else if (tick_reg) begin
            cnt_reg <= nxt;
          end
        end else if (tick_reg) begin
          if ((isint && hit) || (isfix && ovf) || (isvar && (pm1 || (i == 1 && hit)))) begin
            lat_reg <= cmpd;
          end
          if (isint && hit && fn != FN_FREE) begin
            cnt_reg <= 16'h0000;
          end else if (isfix && ovf) begin
            cnt_reg <= 16'h0000;
          end else if (isvar && (pm1 || (i == 1 && hit))) begin
            cnt_reg <= 16'h0000;
          end else begin
            cnt_reg <= nxt;
          end
        end
      end
    end

    // output state: set at start, stepped by matches, held when stopped
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ost_reg <= 1'b0;
        sav_reg <= 1'b0;
        lfn_reg <= FN_RST;
      end else if (!act) begin
        if (runq_reg) begin
          sav_reg <= ost_reg;
        end
        if (fchg) begin
          ost_reg <= (wb[3:0] == lfn_reg) ? sav_reg : 1'b0;
        end
      end else begin
        lfn_reg <= fn;
        if (strt) begin
          ost_reg <= isfix | (~isvar & ~iscap & so_reg[i]);
        end else if (isint && hit) begin
          ost_reg <= ~ost_reg;
        end else if (isfix && (hit || ovf)) begin
          ost_reg <= ovf;
        end else if (pm1) begin
          ost_reg <= 1'b0;
        end else if (isvar && hit && i == 0) begin
          ost_reg <= 1'b1;
        end
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign lower_timer_out = g_ch[0].ost_reg;
  assign upper_timer_out = g_ch[1].ost_reg;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stop_clears;
    !run_reg[0] |=> cntw[0] == 16'h0000;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("count not cleared when stopped");
  property p_join_lock;
    wr_mc && run_reg != 2'b00 && !start_req |=> $stable(join_reg);
  endproperty
  a_join_lock: assert property (p_join_lock) else $error("join changed while running");
  property p_filt_lock;
    wr_mc && run_reg[0] |=> $stable(flt_reg);
  endproperty
  a_filt_lock: assert property (p_filt_lock) else $error("filter changed while running");
  property p_join_clr;
    start_req && join_reg && var0 |=> !join_reg;
  endproperty
  a_join_clr: assert property (p_join_clr) else $error("join not cleared at pwm start");
  property p_zero_wr;
    wr_dat[0] && zblk[0] && !buf16 && !st[0] |=> $stable(data_reg[0]);
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write took effect");
  property p_bf_set;
    pst[0] |=> bf_reg[0];
  endproperty
  a_bf_set: assert property (p_bf_set) else $error("result flag not set");
  property p_wbuf;
    wr_dat[0] && buf16 |=> data_reg[1] == $past(wbuf_reg);
  endproperty
  a_wbuf: assert property (p_wbuf) else $error("write buffer not moved");
  property p_rbuf;
    rd_ud && buf16 |=> rbuf_reg == $past(lraw);
  endproperty
  a_rbuf: assert property (p_rbuf) else $error("read buffer not loaded");
  property p_fix_start;
    strtw[0] && fn_reg[0] == FN_PWMF |=> ost[0] ##1 (ost[0] || hitw[0] || !run_reg[0]);
  endproperty
  a_fix_start: assert property (p_fix_start) else $error("fixed pwm not high at start");
  property p_join_upper;
    join_reg ##1 join_reg |-> cntw[1] == 16'h0000;
  endproperty
  a_join_upper: assert property (p_join_upper) else $error("upper counts while joined");
  property p_cont_match;
    hitw[0] && fn_reg[0] == FN_CONT && !strtw[0] |=> cntw[0] == 16'h0000;
  endproperty
  a_cont_match: assert property (p_cont_match) else $error("count not cleared on match");

  c_pwc: cover property (pst[0] ##[1:20] rd_ld);
  c_cap: cover property (st[1] && capf[1]);
  c_var: cover property (hitw[1] && var0);
endmodule

// *** tb/dct_partner.sv ***
// dct_partner: far-side model of the timer's capture and pulse inputs
// assumes the bench asks for one pulse at a time and holds go for one pclk cycle
`timescale 1ns/1ps
module dct_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] line_sel,
  input wire logic [7:0] width,
  output logic lower_external_input,
  output logic upper_external_input,
  output logic internal_capture_source
);
  // ****************************************
  // pulse source
  // ****************************************
  logic [7:0] left_reg;
  logic [1:0] sel_reg;
  // lines idle low, as a pulled-down input would; one pulse of width cycles on the chosen line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 8'h00;
      sel_reg <= 2'h0;
    end else if (go) begin
      left_reg <= width;
      sel_reg <= line_sel;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign lower_external_input = (left_reg != 8'h00) && (sel_reg == 2'h0);
  assign upper_external_input = (left_reg != 8'h00) && (sel_reg == 2'h1);
  assign internal_capture_source = (left_reg != 8'h00) && (sel_reg == 2'h2);
endmodule

// *** tb/dual_8_16_bit_composite_timer_tb_top.sv ***
// testbench of dct_timer: apb master, far-side pulse model, one task per scenario
// assumes a zero-wait apb slave and CNT_DIV of 1 so one count tick per pclk
`timescale 1ns/1ps
module dual_8_16_bit_composite_timer_tb_top;
  import dct_pkg::*;
  // ****************************************
  // clock, reset and wiring
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, lower_ext, upper_ext, int_src, lower_out, upper_out;
  logic go = 1'b0;
  logic [1:0] line_sel = 2'h0;
  logic [7:0] width = 8'h00;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int cmp_count = 0;
  initial begin
    forever #25 pclk = ~pclk;
  end
  dct_timer #(.CNT_DIV(1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lower_external_input(lower_ext), .upper_external_input(upper_ext), .internal_capture_source(int_src),
    .lower_timer_out(lower_out), .upper_timer_out(upper_out));
  dct_partner u_partner (.pclk(pclk), .presetn(presetn), .go(go), .line_sel(line_sel), .width(width),
    .lower_external_input(lower_ext), .upper_external_input(upper_ext), .internal_capture_source(int_src));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles until lower_timer_out changes level, bounded
  task automatic wait_edge(output int n);
    logic old;
    old = lower_out;
    for (n = 1; n < 2000; n++) begin
      @(posedge pclk);
      if (lower_out !== old) break;
    end
  endtask
  task automatic pulse(input logic [1:0] s, input logic [7:0] w);
    @(posedge pclk);
    go <= 1'b1;
    line_sel <= s;
    width <= w;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk({30'h0, lower_out, upper_out}, 32'h0);
    apb(IDX_UDATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    apb(12'hf99, 1'b1, 8'h55);
    chk({31'h0, err}, 32'h1);
    apb(12'hf99, 1'b0, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_mode_lock();
    for (int v = 0; v < 16; v++) begin
      apb(IDX_MODE, 1'b1, 8'(v));
      apb(IDX_MODE, 1'b0, 8'h00);
      chk({26'h0, rd[5:0]}, 32'(v));
    end
    apb(IDX_MODE, 1'b1, 8'h10);
    apb(IDX_UDATA, 1'b1, 8'h00);
    apb(IDX_LDATA, 1'b1, 8'h20);
    apb(IDX_LCTRL, 1'b1, 8'h81);
    apb(IDX_MODE, 1'b1, 8'h0f);
    apb(IDX_MODE, 1'b0, 8'h00);
    chk({24'h0, rd[7], 1'b0, rd[5:0]}, 32'h10);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    apb(IDX_MODE, 1'b1, 8'h00);
    $display("test mode lock done");
  endtask
  task automatic t_interval();
    int n;
    apb(IDX_LDATA, 1'b1, 8'h04);
    apb(IDX_LCTRL, 1'b1, 8'h01);
    apb(IDX_LCTRL, 1'b1, 8'h81);
    wait_edge(n);
    wait_edge(n);
    chk(32'(n), 32'd5);
    wait_edge(n);
    chk(32'(n), 32'd5);
    apb(IDX_LDATA, 1'b1, 8'h00);
    wait_edge(n);
    wait_edge(n);
    chk(32'(n), 32'd5);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] <= 8'h04}, 32'h1);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    $display("test interval done");
  endtask
  task automatic t_pwm_fixed();
    int lo, hi;
    apb(IDX_LDATA, 1'b1, 8'h02);
    apb(IDX_LCTRL, 1'b1, 8'h03);
    apb(IDX_LCTRL, 1'b1, 8'h83);
    wait_edge(lo);
    if (lower_out !== 1'b0) wait_edge(lo);
    wait_edge(lo);
    wait_edge(hi);
    chk(32'(lo + hi), 32'd256);
    chk(32'(hi), 32'd3);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    $display("test fixed pwm done");
  endtask
  task automatic t_pwm_var();
    int lo, hi;
    apb(IDX_MODE, 1'b1, 8'h10);
    apb(IDX_UDATA, 1'b1, 8'h09);
    apb(IDX_LDATA, 1'b1, 8'h03);
    apb(IDX_LCTRL, 1'b1, 8'h04);
    apb(IDX_LCTRL, 1'b1, 8'h84);
    apb(IDX_MODE, 1'b0, 8'h00);
    chk({31'h0, rd[4]}, 32'h0);
    // first edge ends the opening low phase, then one high and one low phase
    wait_edge(lo);
    wait_edge(hi);
    wait_edge(lo);
    chk(32'(hi), 32'd6);
    chk(32'(lo), 32'd4);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    $display("test variable pwm done");
  endtask
  task automatic t_pulse_width();
    apb(IDX_MODE, 1'b1, 8'h00);
    apb(IDX_LCTRL, 1'b1, 8'h05);
    apb(IDX_LCTRL, 1'b1, 8'h85);
    pulse(2'h0, 8'd20);
    repeat (30) @(posedge pclk);
    apb(IDX_LCTRL, 1'b0, 8'h00);
    chk({31'h0, rd[6]}, 32'h1);
    pulse(2'h0, 8'd40);
    repeat (50) @(posedge pclk);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] >= 8'd18 && rd[7:0] <= 8'd22}, 32'h1);
    apb(IDX_LCTRL, 1'b0, 8'h00);
    chk({31'h0, rd[6]}, 32'h0);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    $display("test pulse width done");
  endtask
  task automatic t_capture();
    apb(IDX_MODE, 1'b1, 8'h20);
    apb(IDX_LCTRL, 1'b1, 8'h0a);
    apb(IDX_LCTRL, 1'b1, 8'h8a);
    apb(IDX_LDATA, 1'b1, 8'h00);
    pulse(2'h0, 8'd8);
    repeat (20) @(posedge pclk);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    pulse(2'h2, 8'd8);
    repeat (20) @(posedge pclk);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] > 8'd20 && rd[7:0] < 8'd80}, 32'h1);
    apb(IDX_MODE, 1'b0, 8'h00);
    chk({31'h0, rd[6]}, 32'h0);
    apb(IDX_LDATA, 1'b1, 8'h5a);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk(rd, 32'h5a);
    // lower filter removes a one-cycle high pulse but passes a longer one
    apb(IDX_LCTRL, 1'b1, 8'h00);
    apb(IDX_MODE, 1'b1, 8'h21);
    apb(IDX_LDATA, 1'b1, 8'h00);
    apb(IDX_LCTRL, 1'b1, 8'h8a);
    pulse(2'h2, 8'd1);
    repeat (10) @(posedge pclk);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk(rd, 32'h0);
    pulse(2'h2, 8'd4);
    repeat (10) @(posedge pclk);
    apb(IDX_LDATA, 1'b0, 8'h00);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    apb(IDX_LCTRL, 1'b1, 8'h00);
    $display("test capture done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode_lock();
    t_interval();
    t_pwm_fixed();
    t_pwm_var();
    t_pulse_width();
    t_capture();
    final_report();
  end
  // the whole run needs under a thousand cycles; a hang is cut off well beyond that
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule
